// ### hw/bsg_status_top.sv
// Baseband and operation status groups with a register command port.
// Assumes the baseband status pins are asynchronous to the clock and
// the operation condition word comes from logic on the same clock.
`timescale 1ns/1ns
module bsg_status_top (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_bb_active,
    input wire logic i_bb_xfer,
    input wire logic [15:0] i_oper_cond,
    input wire logic i_ques_summary,
    input wire logic i_cmd_valid,
    input wire logic i_cmd_write,
    input wire logic [3:0] i_cmd_sel,
    input wire logic [15:0] i_cmd_wdata,
    output logic o_rsp_valid,
    output logic [15:0] o_rsp_data,
    output logic o_stb_oper,
    output logic o_stb_ques,
    output logic o_oper_bb_busy
);
    // ==========================================================
    // Pin synchronisers; a change counts once stages two and three agree.
    function automatic logic settle(input logic [2:0] stages,
        input logic held);
        settle = (stages[1] == stages[2]) ? stages[2] : held;
    endfunction

    logic [2:0] act_sync_r, act_sync_nxt;
    logic act_r, act_nxt;

    always_comb begin
        act_sync_nxt = {act_sync_r[1:0], i_bb_active};
        act_nxt = settle(act_sync_r, act_r); // [RQ5]
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            act_sync_r <= 3'h0;
            act_r <= 1'b0;
        end else begin
            act_sync_r <= act_sync_nxt;
            act_r <= act_nxt;
        end
    end

    // A pin that toggles every clock never settles and keeps its old value.
    logic [2:0] xfr_sync_r, xfr_sync_nxt;
    logic xfr_r, xfr_nxt;

    always_comb begin
        xfr_sync_nxt = {xfr_sync_r[1:0], i_bb_xfer};
        xfr_nxt = settle(xfr_sync_r, xfr_r); // [RQ6]
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            xfr_sync_r <= 3'h0;
            xfr_r <= 1'b0;
        end else begin
            xfr_sync_r <= xfr_sync_nxt;
            xfr_r <= xfr_nxt;
        end
    end

    // ==========================================================
    // Condition words.
    bsg_grp_if bb_g ();
    bsg_grp_if op_g ();
    logic [15:0] bb_cond;
    logic [15:0] op_cond;

    always_comb begin
        bb_cond = bsg_pkg::ZERO16; // [RQ7]
        bb_cond[bsg_pkg::BB_ACTIVE_BIT] = act_r; // [RQ4] [RQ5]
        bb_cond[bsg_pkg::BB_XFER_BIT] = xfr_r; // [RQ4] [RQ6]
    end

    // The baseband summary re-enters as operation bit 10, so its edges
    // pass the operation filters like any other condition bit.
    always_comb begin
        op_cond = i_oper_cond;
        op_cond[bsg_pkg::OPER_BB_BIT] = bb_g.summary; // [RQ3]
        op_cond[bsg_pkg::OPER_ZERO_BIT] = 1'b0;
    end

    // ==========================================================
    // Command decode into group strobes.
    function automatic logic hit(input logic [3:0] sel,
        input logic [3:0] code);
        hit = (sel == code);
    endfunction

    logic wr;
    logic rd;
    assign wr = i_cmd_valid && i_cmd_write;
    assign rd = i_cmd_valid && !i_cmd_write;

    logic bb_ptr_we;
    logic bb_ntr_we;
    logic bb_ena_we;
    logic bb_evt_rd;
    logic op_ptr_we;
    logic op_ntr_we;
    logic op_ena_we;
    logic op_evt_rd;

    // A strobe needs the right direction, so a write never clears events.
    always_comb begin
        bb_ptr_we = 1'b0;
        bb_ntr_we = 1'b0;
        bb_ena_we = 1'b0;
        bb_evt_rd = 1'b0;
        op_ptr_we = 1'b0;
        op_ntr_we = 1'b0;
        op_ena_we = 1'b0;
        op_evt_rd = 1'b0;
        if (hit(i_cmd_sel, bsg_pkg::SEL_BB_PTR)) begin
            bb_ptr_we = wr; // [RQ9]
        end else if (hit(i_cmd_sel, bsg_pkg::SEL_BB_NTR)) begin
            bb_ntr_we = wr; // [RQ9]
        end else if (hit(i_cmd_sel, bsg_pkg::SEL_BB_ENA)) begin
            bb_ena_we = wr; // [RQ12]
        end else if (hit(i_cmd_sel, bsg_pkg::SEL_BB_EVT)) begin
            bb_evt_rd = rd; // [RQ11]
        end else if (hit(i_cmd_sel, bsg_pkg::SEL_OPER_PTR)) begin
            op_ptr_we = wr; // [RQ16]
        end else if (hit(i_cmd_sel, bsg_pkg::SEL_OPER_NTR)) begin
            op_ntr_we = wr; // [RQ16]
        end else if (hit(i_cmd_sel, bsg_pkg::SEL_OPER_ENA)) begin
            op_ena_we = wr; // [RQ1]
        end else if (hit(i_cmd_sel, bsg_pkg::SEL_OPER_EVT)) begin
            op_evt_rd = rd; // [RQ11]
        end
    end

    // Writes to condition or event selects are dropped silently.
    assign bb_g.cond = bb_cond;
    assign bb_g.wdata = i_cmd_wdata;
    assign bb_g.ptr_we = bb_ptr_we;
    assign bb_g.ntr_we = bb_ntr_we;
    assign bb_g.ena_we = bb_ena_we;
    assign bb_g.evt_rd = bb_evt_rd;
    assign op_g.cond = op_cond;
    assign op_g.wdata = i_cmd_wdata;
    assign op_g.ptr_we = op_ptr_we;
    assign op_g.ntr_we = op_ntr_we;
    assign op_g.ena_we = op_ena_we;
    assign op_g.evt_rd = op_evt_rd;

    // ==========================================================
    // Group instances; both use one event logic design.
    bsg_event_group u_bb (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .g(bb_g)
    );

    bsg_event_group u_op (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .g(op_g)
    );

    // ==========================================================
    // Read response, one cycle after the command.
    // Writes answer too, with zero data, so a host can pace one command
    // per answer without tracking which kind it sent.
    logic rsp_valid_r, rsp_valid_nxt;
    logic [15:0] rsp_data_r, rsp_data_nxt;

    always_comb begin
        rsp_valid_nxt = i_cmd_valid;
        rsp_data_nxt = bsg_pkg::ZERO16;
        // Unmapped selects answer zero rather than a stale word.
        if (rd) begin
            if (i_cmd_sel == bsg_pkg::SEL_BB_COND) begin
                rsp_data_nxt = bb_cond; // [RQ8]
            end else if (i_cmd_sel == bsg_pkg::SEL_BB_EVT) begin
                rsp_data_nxt = bb_g.evt; // [RQ11]
            end else if (i_cmd_sel == bsg_pkg::SEL_BB_PTR) begin
                rsp_data_nxt = bb_g.ptr;
            end else if (i_cmd_sel == bsg_pkg::SEL_BB_NTR) begin
                rsp_data_nxt = bb_g.ntr;
            end else if (i_cmd_sel == bsg_pkg::SEL_BB_ENA) begin
                rsp_data_nxt = bb_g.ena; // [RQ13]
            end else if (i_cmd_sel == bsg_pkg::SEL_OPER_COND) begin
                rsp_data_nxt = op_cond;
            end else if (i_cmd_sel == bsg_pkg::SEL_OPER_EVT) begin
                rsp_data_nxt = op_g.evt; // [RQ11]
            end else if (i_cmd_sel == bsg_pkg::SEL_OPER_PTR) begin
                rsp_data_nxt = op_g.ptr;
            end else if (i_cmd_sel == bsg_pkg::SEL_OPER_NTR) begin
                rsp_data_nxt = op_g.ntr;
            end else if (i_cmd_sel == bsg_pkg::SEL_OPER_ENA) begin
                rsp_data_nxt = op_g.ena; // [RQ2]
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r <= bsg_pkg::ZERO16;
        end else begin
            rsp_valid_r <= rsp_valid_nxt;
            rsp_data_r <= rsp_data_nxt;
        end
    end

    // ==========================================================
    // Status outputs.
    assign o_rsp_valid = rsp_valid_r;
    assign o_rsp_data = rsp_data_r;

    // Summaries stay combinational so a cleared event drops them at once.
    // The questionable summary is built outside and only passes through.
    assign o_stb_oper = op_g.summary; // [RQ1]
    assign o_stb_ques = i_ques_summary; // [RQ14]
    assign o_oper_bb_busy = bb_g.summary; // [RQ3]
endmodule // bsg_status_top

// ### pkg/bsg_pkg.sv
// Constants shared by the baseband status group and its event filter.
// Assumes one 125 MHz clock and an active-low asynchronous reset.
//
// Functional notes
// RQ1 - Operation enable mask drives status bit 7.
// RQ2 - Operation enable mask reads back as written.
// RQ3 - Baseband summary drives operation condition bit 10.
// RQ4 - Baseband condition follows live status; read only.
// RQ5 - Condition bit 0 shows baseband active.
// RQ6 - Condition bit 1 shows baseband transferring data.
// RQ7 - Condition bits 2 to 15 read zero.
// RQ8 - Condition query returns bits currently set.
// RQ9 - Per-bit positive and negative transition filters.
// RQ10 - Event bits set on filtered edges, hold.
// RQ11 - Event read returns contents and clears them.
// RQ12 - Baseband enable mask gates the baseband summary.
// RQ13 - Baseband enable mask reads back as written.
// RQ14 - Questionable summary drives status bit 3.
// RQ15 - Summary is OR of event AND enable.
// RQ16 - Operation events latch filtered condition edges.
package bsg_pkg;
    // ==========================================================
    // Register widths and field positions.
    localparam int unsigned REG_W = 16;
    localparam int unsigned BB_ACTIVE_BIT = 0;
    localparam int unsigned BB_XFER_BIT = 1;
    localparam int unsigned OPER_BB_BIT = 10;
    localparam int unsigned OPER_ZERO_BIT = 15;
    localparam int unsigned SEL_W = 4;

    // ==========================================================
    // Reset values of the writable masks.
    localparam logic [15:0] PTR_RST = 16'hFFFF;
    localparam logic [15:0] NTR_RST = 16'h0000;
    localparam logic [15:0] ENA_RST = 16'h0000;
    localparam logic [15:0] ZERO16 = 16'h0000;

    // ==========================================================
    // Register select codes on the command port.
    localparam logic [3:0] SEL_OPER_COND = 4'h0;
    localparam logic [3:0] SEL_OPER_EVT = 4'h1;
    localparam logic [3:0] SEL_OPER_PTR = 4'h2;
    localparam logic [3:0] SEL_OPER_NTR = 4'h3;
    localparam logic [3:0] SEL_OPER_ENA = 4'h4;
    localparam logic [3:0] SEL_BB_COND = 4'h8;
    localparam logic [3:0] SEL_BB_EVT = 4'h9;
    localparam logic [3:0] SEL_BB_PTR = 4'hA;
    localparam logic [3:0] SEL_BB_NTR = 4'hB;
    localparam logic [3:0] SEL_BB_ENA = 4'hC;
endpackage

// ### pkg/bsg_grp_if.sv
// Signals between the top and one event filter group.
// Assumes both ends share the same clock.
`timescale 1ns/1ns
interface bsg_grp_if;
    logic [15:0] cond;
    logic [15:0] wdata;
    logic ptr_we;
    logic ntr_we;
    logic ena_we;
    logic evt_rd;
    logic [15:0] evt;
    logic [15:0] ptr;
    logic [15:0] ntr;
    logic [15:0] ena;
    logic summary;

    modport grp (
        input cond, wdata, ptr_we, ntr_we, ena_we, evt_rd,
        output evt, ptr, ntr, ena, summary
    );
    modport ctl (
        output cond, wdata, ptr_we, ntr_we, ena_we, evt_rd,
        input evt, ptr, ntr, ena, summary
    );
endinterface // bsg_grp_if

// ### hw/bsg_event_group.sv
// Transition filters, event register and enable mask of one group.
// Assumes the condition word is already in the local clock domain.
`timescale 1ns/1ns
module bsg_event_group (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    bsg_grp_if.grp g
);
    // ==========================================================
    // Registers.
    logic [15:0] prev_r, prev_nxt;
    logic [15:0] evt_r, evt_nxt;
    logic [15:0] ptr_r, ptr_nxt;
    logic [15:0] ntr_r, ntr_nxt;
    logic [15:0] ena_r, ena_nxt;
    logic [15:0] rise, fall;

    always_comb begin
        rise = g.cond & ~prev_r & ptr_r; // [RQ9]
        fall = ~g.cond & prev_r & ntr_r; // [RQ9]
        prev_nxt = g.cond;
        // A read clears, but an edge in the same cycle survives.
        evt_nxt = g.evt_rd ? bsg_pkg::ZERO16 : evt_r; // [RQ11]
        evt_nxt = evt_nxt | rise | fall; // [RQ10] [RQ16]
        ptr_nxt = g.ptr_we ? g.wdata : ptr_r;
        ntr_nxt = g.ntr_we ? g.wdata : ntr_r;
        ena_nxt = g.ena_we ? g.wdata : ena_r; // [RQ2] [RQ13]
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prev_r <= bsg_pkg::ZERO16;
            evt_r <= bsg_pkg::ZERO16;
            ptr_r <= bsg_pkg::PTR_RST;
            ntr_r <= bsg_pkg::NTR_RST;
            ena_r <= bsg_pkg::ENA_RST;
        end else begin
            prev_r <= prev_nxt;
            evt_r <= evt_nxt;
            ptr_r <= ptr_nxt;
            ntr_r <= ntr_nxt;
            ena_r <= ena_nxt;
        end
    end

    assign g.evt = evt_r;
    assign g.ptr = ptr_r;
    assign g.ntr = ntr_r;
    assign g.ena = ena_r;
    assign g.summary = |(evt_r & ena_r); // [RQ15] [RQ1] [RQ12]
endmodule // bsg_event_group

// ### bench/bsg_status_monitor.sv
// Port checks for the baseband status block.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ns
module bsg_status_monitor (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_bb_active,
    input wire logic i_bb_xfer,
    input wire logic [15:0] i_oper_cond,
    input wire logic i_ques_summary,
    input wire logic i_cmd_valid,
    input wire logic i_cmd_write,
    input wire logic [3:0] i_cmd_sel,
    input wire logic [15:0] i_cmd_wdata,
    input wire logic o_rsp_valid,
    input wire logic [15:0] o_rsp_data,
    input wire logic o_stb_oper,
    input wire logic o_stb_ques,
    input wire logic o_oper_bb_busy
);
    // ==========================================================
    // Checks.
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    wire logic rd = i_cmd_valid && !i_cmd_write;
    wire logic wr = i_cmd_valid && i_cmd_write;
    chk_rsp_follows: assert property (i_cmd_valid |=> o_rsp_valid)
        else $error("no response after command");
    chk_rsp_cause: assert property (
        o_rsp_valid |-> $past(i_cmd_valid))
        else $error("response without command");
    chk_ques_pass: assert property (o_stb_ques == i_ques_summary)
        else $error("questionable summary wrong");
    chk_write_nodata: assert property (wr |=> o_rsp_data == 16'h0000)
        else $error("write returned data");
    chk_cond_high_zero: assert property (
        rd && i_cmd_sel == 4'h8 |=> o_rsp_data[15:2] == 14'h0000)
        else $error("unused condition bits set");
    // Six stable samples cover the pin synchroniser latency.
    chk_cond_pins: assert property (
        $stable({i_bb_xfer, i_bb_active})[*6] ##0 (rd && i_cmd_sel == 4'h8)
        |=> o_rsp_data[1:0] == $past({i_bb_xfer, i_bb_active}))
        else $error("condition does not follow pins");
    chk_bb_ena_off: assert property (
        wr && i_cmd_sel == 4'hC && i_cmd_wdata == 16'h0000
        |=> !o_oper_bb_busy) else $error("masked baseband summary set");
    chk_op_ena_off: assert property (
        wr && i_cmd_sel == 4'h4 && i_cmd_wdata == 16'h0000
        |=> !o_stb_oper) else $error("masked operation summary set");
    cover property (o_stb_oper);
    cover property (o_oper_bb_busy);
    cover property (o_rsp_valid && o_rsp_data != 16'h0000);
endmodule // bsg_status_monitor

bind bsg_status_top bsg_status_monitor u_mon (.i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn), .i_bb_active(i_bb_active), .i_bb_xfer(i_bb_xfer),
    .i_oper_cond(i_oper_cond), .i_ques_summary(i_ques_summary),
    .i_cmd_valid(i_cmd_valid), .i_cmd_write(i_cmd_write),
    .i_cmd_sel(i_cmd_sel), .i_cmd_wdata(i_cmd_wdata),
    .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
    .o_stb_oper(o_stb_oper), .o_stb_ques(o_stb_ques),
    .o_oper_bb_busy(o_oper_bb_busy));

// ### bench/baseband_status_group_tb.sv
// Testbench for the baseband status block.
// Assumes a one-cycle response to every command on the register port.
`timescale 1ns/1ns
module baseband_status_group_tb;
    logic clk = 1'b0, rstn = 1'b0, act = 1'b0, xfr = 1'b0, ques = 1'b0;
    logic cv = 1'b0, cw = 1'b0, rv, so, sq, bb;
    logic [3:0] cs = 4'h0;
    logic [15:0] cd = 16'h0000, oc = 16'h0000, dv;
    int err_count = 0, samples_checked = 0;
    bsg_status_top uut (.i_ref_clk(clk), .i_rstn(rstn), .i_bb_active(act),
        .i_bb_xfer(xfr), .i_oper_cond(oc), .i_ques_summary(ques),
        .i_cmd_valid(cv), .i_cmd_write(cw), .i_cmd_sel(cs),
        .i_cmd_wdata(cd), .o_rsp_valid(rv), .o_rsp_data(dv),
        .o_stb_oper(so), .o_stb_ques(sq), .o_oper_bb_busy(bb));
    initial begin
        forever #4 clk = ~clk;
    end
    // ==========================================================
    // Tasks.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic w, input logic [3:0] s,
        input logic [15:0] d);
        @(negedge clk);
        {cv, cw, cs, cd} = {1'b1, w, s, d};
        @(negedge clk);
        cv = 1'b0;
    endtask
    task automatic rdc(input logic [3:0] s, input logic [15:0] exp);
        cmd(1'b0, s, 16'h0000);
        chk({15'h0000, rv}, 16'h0001);
        chk(dv, exp);
    endtask
    // Pins need up to four edges through the synchroniser.
    task automatic idle();
        repeat (8) @(negedge clk);
    endtask
    task automatic wrap_up();
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // Sequence.
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        rdc(4'hA, 16'hFFFF);
        rdc(4'hB, 16'h0000);
        rdc(4'hC, 16'h0000);
        rdc(4'h2, 16'hFFFF);
        rdc(4'h4, 16'h0000);
        rdc(4'h5, 16'h0000);
        act = 1'b1;
        idle();
        rdc(4'h8, 16'h0001);
        xfr = 1'b1;
        idle();
        cmd(1'b1, 4'h8, 16'hFFFF);
        rdc(4'h8, 16'h0003);
        rdc(4'h9, 16'h0003);
        rdc(4'h9, 16'h0000);
        cmd(1'b1, 4'hB, 16'h0001);
        cmd(1'b1, 4'hA, 16'h0000);
        act = 1'b0;
        idle();
        xfr = 1'b0;
        idle();
        rdc(4'h9, 16'h0001);
        cmd(1'b1, 4'hA, 16'h0002);
        cmd(1'b1, 4'hC, 16'h0002);
        rdc(4'hC, 16'h0002);
        oc = 16'h8008;
        xfr = 1'b1;
        idle();
        chk({15'h0000, bb}, 16'h0001);
        rdc(4'h0, 16'h0408);
        cmd(1'b1, 4'h4, 16'h0400);
        chk({15'h0000, so}, 16'h0001);
        rdc(4'h4, 16'h0400);
        rdc(4'h1, 16'h0408);
        chk({15'h0000, so}, 16'h0000);
        rdc(4'h9, 16'h0002);
        chk({15'h0000, bb}, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            @(negedge clk);
            ques = i[0];
            #1;
            chk({15'h0000, sq}, {15'h0000, i[0]});
        end
        // Fresh events on both groups, then masking must drop each summary.
        @(negedge clk);
        oc = 16'h0010;
        xfr = 1'b0;
        idle();
        xfr = 1'b1;
        idle();
        chk({15'h0000, bb}, 16'h0001);
        chk({15'h0000, so}, 16'h0001);
        cmd(1'b1, 4'hC, 16'h0000);
        chk({15'h0000, bb}, 16'h0000);
        cmd(1'b1, 4'h4, 16'h0000);
        chk({15'h0000, so}, 16'h0000);
        rdc(4'h1, 16'h0410);
        wrap_up();
    end
endmodule // baseband_status_group_tb
